// [rtl/asr_pkg.sv]
/*
 Constants, register map and carrier types of the autosense read controller.
 Assumes one 125 MHz clock and an APB master reaching the registers.
*/
// Overview of operation
// - Mode select 3 enters autosense; 0-2 leave.
// - Autosense ignores serial and pin triggers.
// - Autosense refuses upload, hex, macro, continuous, test.
// - View change starts capture and decode attempts.
// - Good read sends data, green, good output.
// - Failed read sends error, red, fail output.
// - Guarded repeat read gives nothing, no count.
// - Guard switch on/off; window 1-40 x500ms.
// - Decode timeout 100-30000 ms, default 5 s.
// - Absence or presence-ignore time re-arms waiting.
// - Presence-ignore code 0-7 selects 100-3000 ms.
// - Motion sensitivity setting 0 to 4.
// - Flash illumination in autosense when switch on.
// - Status query reports sensing settings.
// - Decode area codes 0-3 pick 100-25 percent.
// - Capture illumination 2 off, 3 pulsed on.
// - Two independent illumination source enables.
// - Illumination intensity 0 off to 50.
// - Shutter code 0-8 picks 1/60 to 1/8000.
// - Extra gain 1 to 15.
// - Black level signed -127 to 127.
// - Mirror order code 0-3 selects read order.
package asr_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_SENSE = 8'h04;
  localparam logic [7:0] OFF_TMO = 8'h08;
  localparam logic [7:0] OFF_CAM = 8'h0c;
  localparam logic [7:0] OFF_REQ = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  // Mode select value for autosense
  localparam logic [1:0] MODE_AUTO = 2'h3;
  // Reset values, range limits and fixed codes
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [14:0] RST_TMO_MS = 15'h1388;
  localparam logic [14:0] TMO_MIN_MS = 15'h0064;
  localparam logic [14:0] TMO_MAX_MS = 15'h7530;
  localparam logic [2:0] RST_PRES = 3'h2;
  localparam logic [5:0] RST_GWIN = 6'h06;
  localparam logic [5:0] GWIN_MAX = 6'h28;
  localparam logic [2:0] RST_SENS = 3'h2;
  localparam logic [2:0] SENS_MAX = 3'h4;
  localparam logic [5:0] INT_MAX = 6'h32;
  localparam logic [3:0] SHUT_MAX = 4'h8;
  localparam logic [3:0] GAIN_MIN = 4'h1;
  localparam logic [7:0] BLACK_MIN = 8'h81;
  localparam logic [1:0] ILL_OFF = 2'h2;
  localparam logic [1:0] ILL_PULSE = 2'h3;
  localparam logic [14:0] GWIN_STEP_MS = 15'h01f4;
  // Field positions in the sense register
  localparam int SN_PRES = 0;
  localparam int SN_GEN = 3;
  localparam int SN_GWIN = 4;
  localparam int SN_FLASH = 10;
  localparam int SN_SENS = 11;
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
  localparam int BLINK_BIT = 7;

  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_READ = 2'b01,
    ST_HOLD = 2'b10
  } asr_state_e;

  // Camera settings, packed as in the camera register
  typedef struct packed {
    logic [1:0] mirror;
    logic [7:0] black;
    logic [3:0] gain;
    logic [3:0] shutter;
    logic [5:0] intensity;
    logic [1:0] src_en;
    logic [1:0] illum_ctl;
    logic [1:0] win_v;
    logic [1:0] win_h;
  } asr_cam_s;

  localparam asr_cam_s RST_CAM = '{mirror: 2'h0, black: 8'h00, gain: 4'h1,
    shutter: 4'h3, intensity: 6'h19, src_en: 2'h3, illum_ctl: 2'h3,
    win_v: 2'h0, win_h: 2'h0};

  // Decoder verdict
  typedef struct packed {
    logic done;
    logic ok;
    logic same;
  } asr_dec_s;
endpackage

// [rtl/asr_top.sv]
/*
 Autosense read controller: APB registers, sensing state machine,
 result outputs and per-read camera settings.
 Assumes the image path flags view changes and presence, and a decoder
 reports each attempt's verdict, all synchronous to CLOCK_I.
*/
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
module asr_top #(
  parameter int CYC_MS = asr_pkg::CYC_PER_MS
) (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Sensing and decoder inputs
  input wire logic CHANGE_I,
  input wire logic PRESENT_I,
  input wire asr_pkg::asr_dec_s DEC_I,
  input wire logic TRIG_I,
  // Trigger and request forwarding
  output logic TRIG_O,
  output logic [4:0] REQ_O,
  // Read results
  output logic TX_DATA_O,
  output logic TX_ERR_O,
  output logic GREEN_O,
  output logic RED_O,
  output logic GOOD_O,
  output logic FAIL_O,
  // Camera control
  output logic CAPTURE_O,
  output logic MIRROR_O,
  output logic ILLUM_O,
  output asr_pkg::asr_cam_s CAM_O,
  output logic [9:0] WIN_W_O,
  output logic [8:0] WIN_H_O,
  output logic [12:0] EXPO_DIV_O,
  output logic [2:0] SENS_O
);
  import asr_pkg::*;

  // ==========================================================
  // Register bus
  logic [1:0] mode_q;
  logic [2:0] pres_q;
  logic gen_q;
  logic [5:0] gwin_q;
  logic flash_q;
  logic [2:0] sens_q;
  logic [14:0] tmo_q;
  asr_cam_s cam_q;
  logic [31:0] rdata_q;
  logic refused_q;
  logic [15:0] cnt_q;
  asr_state_e st_q;

  wire setup = PSEL_I && !PENABLE_I;
  wire wr = PSEL_I && PENABLE_I && PWRITE_I;
  wire hit_mode = PADDR_I == OFF_MODE;
  wire hit_sense = PADDR_I == OFF_SENSE;
  wire hit_tmo = PADDR_I == OFF_TMO;
  wire hit_cam = PADDR_I == OFF_CAM;
  wire hit_req = PADDR_I == OFF_REQ;
  wire hit_stat = PADDR_I == OFF_STAT;
  wire mapped = hit_mode | hit_sense | hit_tmo | hit_cam | hit_req | hit_stat;
  wire auto_on = mode_q == MODE_AUTO;
  wire req_wr = wr && hit_req;

  wire [31:0] sense_rd = {18'h0, sens_q, flash_q, gwin_q, gen_q, pres_q};
  wire [31:0] stat_rd = {12'h0, cnt_q, 1'b0, refused_q, st_q};
  wire [31:0] rd_mux = hit_mode ? {30'h0, mode_q} :
                       hit_sense ? sense_rd :
                       hit_tmo ? {17'h0, tmo_q} :
                       hit_cam ? cam_q : hit_stat ? stat_rd : 32'h0;

  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
  assign PRDATA_O = rdata_q;

  // Out-of-range writes saturate to the nearest legal value
  asr_cam_s wc;
  assign wc = asr_cam_s'(PWDATA_I);
  wire [5:0] w_gwin = PWDATA_I[SN_GWIN +: 6];
  wire [2:0] w_sens = PWDATA_I[SN_SENS +: 3];
  wire [14:0] w_tmo = PWDATA_I[14:0];
  wire w_tmo_big = |PWDATA_I[31:15] || w_tmo > TMO_MAX_MS;
  wire [14:0] tmo_d = w_tmo_big ? TMO_MAX_MS : w_tmo < TMO_MIN_MS ? TMO_MIN_MS : w_tmo;
  wire [5:0] gwin_d = w_gwin == 6'h0 ? 6'h01 : w_gwin > GWIN_MAX ? GWIN_MAX : w_gwin;
  wire [2:0] sens_d = w_sens > SENS_MAX ? SENS_MAX : w_sens;
  asr_cam_s cam_d;
  always_comb begin
    cam_d = wc;
    cam_d.illum_ctl = wc.illum_ctl[1] ? wc.illum_ctl : ILL_OFF;
    cam_d.intensity = wc.intensity > INT_MAX ? INT_MAX : wc.intensity;
    cam_d.shutter = wc.shutter > SHUT_MAX ? SHUT_MAX : wc.shutter;
    cam_d.gain = wc.gain < GAIN_MIN ? GAIN_MIN : wc.gain;
    cam_d.black = wc.black == 8'h80 ? BLACK_MIN : wc.black;
  end

  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      mode_q <= RST_MODE;
      pres_q <= RST_PRES;
      gen_q <= 1'b0;
      gwin_q <= RST_GWIN;
      flash_q <= 1'b0;
      sens_q <= RST_SENS;
      tmo_q <= RST_TMO_MS;
      cam_q <= RST_CAM;
      rdata_q <= 32'h0;
    end else begin
      if (setup) rdata_q <= rd_mux;
      if (wr && hit_mode) mode_q <= PWDATA_I[1:0];
      if (wr && hit_sense) begin
        pres_q <= PWDATA_I[SN_PRES +: 3];
        gen_q <= PWDATA_I[SN_GEN];
        gwin_q <= gwin_d;
        flash_q <= PWDATA_I[SN_FLASH];
        sens_q <= sens_d;
      end
      if (wr && hit_tmo) tmo_q <= tmo_d;
      if (wr && hit_cam) cam_q <= cam_d;
    end
  end

  // ==========================================================
  // Triggers and refused requests
  // Request bits: 0 upload, 1 hex, 2 macro, 3 continuous, 4 test
  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      TRIG_O <= 1'b0;
      REQ_O <= 5'h0;
      refused_q <= 1'b0;
    end else begin
      TRIG_O <= !auto_on && (TRIG_I || (req_wr && PWDATA_I[5]));
      REQ_O <= (req_wr && !auto_on) ? PWDATA_I[4:0] : 5'h0;
      if (req_wr && auto_on && |PWDATA_I[5:0]) refused_q <= 1'b1;
      else if (wr && hit_stat && PWDATA_I[2]) refused_q <= 1'b0;
    end
  end

  // ==========================================================
  // Millisecond tick and timers
  logic [16:0] div_q;
  logic [14:0] tmr_q;
  logic [14:0] guard_q;
  logic [7:0] blink_q;
  wire tick = div_q == 17'(CYC_MS - 1);

  // Presence-ignore times in ms
  function automatic logic [14:0] pres_ms(input logic [2:0] c);
    case (c)
      3'h0: pres_ms = 15'h0064;
      3'h1: pres_ms = 15'h012c;
      3'h2: pres_ms = 15'h01f4;
      3'h3: pres_ms = 15'h03e8;
      3'h4: pres_ms = 15'h05dc;
      3'h5: pres_ms = 15'h07d0;
      3'h6: pres_ms = 15'h09c4;
      default: pres_ms = 15'h0bb8;
    endcase
  endfunction

  // ==========================================================
  // Sensing state machine
  asr_state_e st_d;
  asr_cam_s act_q;
  logic [14:0] act_tmo_q;
  logic [2:0] act_pres_q;
  logic act_gen_q;
  logic [5:0] act_gwin_q;
  logic mir_q;
  logic second_q;

  wire start = st_q == ST_WAIT && auto_on && CHANGE_I;
  wire reading = st_q == ST_READ;
  wire good = reading && DEC_I.done && DEC_I.ok;
  wire supp = good && act_gen_q && DEC_I.same && guard_q != 15'h0;
  wire timeout = reading && !good && tick && tmr_q >= act_tmo_q - 15'h1;
  wire retry = reading && DEC_I.done && !DEC_I.ok && act_q.mirror[1] && !second_q;
  wire hold_end = st_q == ST_HOLD &&
    (!PRESENT_I || (tick && tmr_q >= pres_ms(act_pres_q) - 15'h1));
  wire [14:0] gwin_ms = 15'(act_gwin_q * GWIN_STEP_MS);

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_WAIT: if (start) st_d = ST_READ;
      ST_READ: if (good || timeout) st_d = ST_HOLD;
      ST_HOLD: if (hold_end) st_d = ST_WAIT;
      default: st_d = ST_WAIT;
    endcase
    if (!auto_on) st_d = ST_WAIT;
  end

  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      st_q <= ST_WAIT;
      div_q <= 17'h0;
      tmr_q <= 15'h0;
      guard_q <= 15'h0;
      blink_q <= 8'h0;
    end else begin
      st_q <= st_d;
      div_q <= tick ? 17'h0 : div_q + 17'h1;
      if (st_d != st_q) tmr_q <= 15'h0;
      else if (tick && tmr_q != 15'h7fff) tmr_q <= tmr_q + 15'h1;
      if (good && !supp) guard_q <= gwin_ms;
      else if (tick && guard_q != 15'h0) guard_q <= guard_q - 15'h1;
      if (tick) blink_q <= blink_q + 8'h1;
    end
  end

  // Settings frozen per read so a mid-read write cannot tear it
  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      act_q <= RST_CAM;
      act_tmo_q <= RST_TMO_MS;
      act_pres_q <= RST_PRES;
      act_gen_q <= 1'b0;
      act_gwin_q <= RST_GWIN;
      mir_q <= 1'b0;
      second_q <= 1'b0;
    end else if (start) begin
      act_q <= cam_q;
      act_tmo_q <= tmo_q;
      act_pres_q <= pres_q;
      act_gen_q <= gen_q;
      act_gwin_q <= gwin_q;
      mir_q <= cam_q.mirror[0];
      second_q <= 1'b0;
    end else if (retry) begin
      mir_q <= !mir_q;
      second_q <= 1'b1;
    end
  end

  // ==========================================================
  // Results
  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      TX_DATA_O <= 1'b0;
      TX_ERR_O <= 1'b0;
      GREEN_O <= 1'b0;
      RED_O <= 1'b0;
      GOOD_O <= 1'b0;
      FAIL_O <= 1'b0;
      cnt_q <= 16'h0;
    end else begin
      TX_DATA_O <= good && !supp;
      TX_ERR_O <= timeout;
      if (start || !auto_on) begin
        GREEN_O <= 1'b0;
        RED_O <= 1'b0;
        GOOD_O <= 1'b0;
        FAIL_O <= 1'b0;
      end else if (good && !supp) begin
        GREEN_O <= 1'b1;
        GOOD_O <= 1'b1;
      end else if (timeout) begin
        RED_O <= 1'b1;
        FAIL_O <= 1'b1;
      end
      if ((good && !supp) || timeout) cnt_q <= cnt_q + 16'h1;
    end
  end

  // ==========================================================
  // Camera outputs
  logic [9:0] win_w_d;
  logic [8:0] win_h_d;
  logic [12:0] expo_d;
  always_comb begin
    unique case (act_q.win_h)
      2'h0: win_w_d = 10'h2f0;
      2'h1: win_w_d = 10'h234;
      2'h2: win_w_d = 10'h178;
      2'h3: win_w_d = 10'h0bc;
    endcase
    unique case (act_q.win_v)
      2'h0: win_h_d = 9'h1e0;
      2'h1: win_h_d = 9'h168;
      2'h2: win_h_d = 9'h0f0;
      2'h3: win_h_d = 9'h078;
    endcase
    case (act_q.shutter)
      4'h0: expo_d = 13'h003c;
      4'h1: expo_d = 13'h007d;
      4'h2: expo_d = 13'h00fa;
      4'h3: expo_d = 13'h01f4;
      4'h4: expo_d = 13'h03e8;
      4'h5: expo_d = 13'h07d0;
      4'h6: expo_d = 13'h0fa0;
      4'h7: expo_d = 13'h1770;
      default: expo_d = 13'h1f40;
    endcase
  end

  wire cap_illum = act_q.illum_ctl == ILL_PULSE && act_q.intensity != 6'h0;
  wire sense_flash = auto_on && flash_q && st_q == ST_WAIT && blink_q[BLINK_BIT];

  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      CAPTURE_O <= 1'b0;
      MIRROR_O <= 1'b0;
      ILLUM_O <= 1'b0;
      CAM_O <= RST_CAM;
      WIN_W_O <= 10'h0;
      WIN_H_O <= 9'h0;
      EXPO_DIV_O <= 13'h0;
      SENS_O <= RST_SENS;
    end else begin
      CAPTURE_O <= st_d == ST_READ;
      MIRROR_O <= mir_q;
      ILLUM_O <= reading ? cap_illum : sense_flash;
      CAM_O <= act_q;
      WIN_W_O <= win_w_d;
      WIN_H_O <= win_h_d;
      EXPO_DIV_O <= expo_d;
      SENS_O <= sens_q;
    end
  end

  // ==========================================================
  // Checks
  property p_mode_exit;
    @(posedge CLOCK_I) disable iff (!NRST_I) !auto_on |=> st_q == ST_WAIT;
  endproperty
  a_mode_exit: assert property (p_mode_exit) else $error("left autosense but busy");

  property p_trig_block;
    @(posedge CLOCK_I) disable iff (!NRST_I) auto_on && $past(auto_on) |-> !TRIG_O;
  endproperty
  a_trig_block: assert property (p_trig_block) else $error("trigger passed in autosense");

  property p_refuse;
    @(posedge CLOCK_I) disable iff (!NRST_I) req_wr && auto_on |=> REQ_O == 5'h0 && refused_q;
  endproperty
  a_refuse: assert property (p_refuse) else $error("request not refused");

  property p_start;
    @(posedge CLOCK_I) disable iff (!NRST_I) start |=> CAPTURE_O && reading;
  endproperty
  a_start: assert property (p_start) else $error("change did not start read");

  property p_good;
    @(posedge CLOCK_I) disable iff (!NRST_I)
      good && !supp |=> TX_DATA_O && GREEN_O && GOOD_O && !RED_O ##1 !TX_DATA_O;
  endproperty
  a_good: assert property (p_good) else $error("good read result wrong");

  property p_fail;
    @(posedge CLOCK_I) disable iff (!NRST_I) timeout |=> TX_ERR_O && RED_O && FAIL_O && !GREEN_O;
  endproperty
  a_fail: assert property (p_fail) else $error("failed read result wrong");

  property p_supp;
    @(posedge CLOCK_I) disable iff (!NRST_I)
      supp |=> !TX_DATA_O && !GOOD_O && !FAIL_O && cnt_q == $past(cnt_q);
  endproperty
  a_supp: assert property (p_supp) else $error("repeat read not suppressed");

  property p_tmo_range;
    @(posedge CLOCK_I) disable iff (!NRST_I) tmo_q >= TMO_MIN_MS && tmo_q <= TMO_MAX_MS;
  endproperty
  a_tmo_range: assert property (p_tmo_range) else $error("timeout out of range");

  property p_illum_off;
    @(posedge CLOCK_I) disable iff (!NRST_I)
      reading && act_q.illum_ctl == ILL_OFF |=> !ILLUM_O;
  endproperty
  a_illum_off: assert property (p_illum_off) else $error("illumination on in off mode");

  property p_gain;
    @(posedge CLOCK_I) disable iff (!NRST_I) cam_q.gain >= GAIN_MIN && cam_q.black != 8'h80;
  endproperty
  a_gain: assert property (p_gain) else $error("gain or black level out of range");

  c_good: cover property (@(posedge CLOCK_I) disable iff (!NRST_I) good && !supp);
  c_fail: cover property (@(posedge CLOCK_I) disable iff (!NRST_I) timeout);
  c_supp: cover property (@(posedge CLOCK_I) disable iff (!NRST_I) supp);
  c_retry: cover property (@(posedge CLOCK_I) disable iff (!NRST_I) retry);
endmodule // asr_top

// [verif/asr_dec_model.sv]
/*
 Image path and decoder stand-in for the autosense read controller.
 Assumes CAPTURE_O qualifies attempts; one verdict every 8 cycles of capture.
*/
`timescale 1ns/1ps
module asr_dec_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Control from bench and design
  input wire logic capture_i,
  input wire logic [3:0] ok_at_i,
  input wire logic same_i,
  // Verdict to design
  output asr_pkg::asr_dec_s dec_o
);
  import asr_pkg::*;
  logic [2:0] div_q;
  logic [3:0] att_q;
  // Zero ok_at_i means no attempt ever succeeds
  always_ff @(posedge clk_i) begin
    if (!nrst_i || !capture_i) begin
      div_q <= 3'h0;
      att_q <= 4'h0;
      dec_o <= '0;
    end else begin
      div_q <= div_q + 3'h1;
      dec_o <= '0;
      if (div_q == 3'h7) begin
        att_q <= att_q + 4'h1;
        dec_o.done <= 1'b1;
        dec_o.ok <= (ok_at_i != 4'h0) && (att_q + 4'h1 >= ok_at_i);
        dec_o.same <= same_i;
      end
    end
  end
endmodule // asr_dec_model

// [verif/asr_top_tb_top.sv]
/*
 Self-checking bench of the autosense read controller.
 Assumes the design scaled to 10 cycles per millisecond; APB waits on ready.
*/
`timescale 1ns/1ps
module asr_top_tb_top;
  import asr_pkg::*;
  logic clk, nrst, psel, penable, pwrite, change, present, trig, same;
  logic [7:0] paddr;
  logic [31:0] pwdata, rdat, cam, PRDATA_O;
  logic rerr, PREADY_O, PSLVERR_O, TRIG_O, TX_DATA_O, TX_ERR_O, GREEN_O, RED_O;
  logic GOOD_O, FAIL_O, CAPTURE_O, MIRROR_O, ILLUM_O, ill_q;
  logic [3:0] ok_at;
  logic [4:0] REQ_O, req_or;
  logic [9:0] WIN_W_O;
  logic [8:0] WIN_H_O;
  logic [12:0] EXPO_DIV_O;
  logic [2:0] SENS_O;
  asr_cam_s CAM_O, c;
  asr_dec_s dec;
  int n_fail, total_checks, cyc, n_trig, n_tx, n_err, n_ill, n;
  asr_top #(.CYC_MS(10)) DUT (.CLOCK_I(clk), .NRST_I(nrst), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .CHANGE_I(change), .PRESENT_I(present), .DEC_I(dec), .TRIG_I(trig),
    .TRIG_O(TRIG_O), .REQ_O(REQ_O), .TX_DATA_O(TX_DATA_O), .TX_ERR_O(TX_ERR_O),
    .GREEN_O(GREEN_O), .RED_O(RED_O), .GOOD_O(GOOD_O), .FAIL_O(FAIL_O),
    .CAPTURE_O(CAPTURE_O), .MIRROR_O(MIRROR_O), .ILLUM_O(ILLUM_O), .CAM_O(CAM_O),
    .WIN_W_O(WIN_W_O), .WIN_H_O(WIN_H_O), .EXPO_DIV_O(EXPO_DIV_O), .SENS_O(SENS_O));
  asr_dec_model u_dec (.clk_i(clk), .nrst_i(nrst), .capture_i(CAPTURE_O),
    .ok_at_i(ok_at), .same_i(same), .dec_o(dec));
  // ==========================================
  // Clock, monitors, hang guard
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    n_trig += int'(TRIG_O === 1'b1);
    n_tx += int'(TX_DATA_O === 1'b1);
    n_err += int'(TX_ERR_O === 1'b1);
    req_or |= REQ_O;
    n_ill += int'(ILLUM_O !== ill_q);
    ill_q = ILLUM_O;
    if (cyc == 60000) begin
      n_fail++;
      test_done();
    end
  end
  // ==========================================
  // Shared tasks and expectations
  task automatic test_done();
    if (n_fail == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // Only the hang guard ends a wait for ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (PREADY_O !== 1'b1);
    rdat = PRDATA_O;
    rerr = PSLVERR_O;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wcap(input logic v, input int lim);
    n = 0;
    while (CAPTURE_O !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(CAPTURE_O === v, "capture wait");
  endtask
  task automatic wst(input logic [1:0] s);
    int k;
    k = 0;
    do begin
      apb(1'b0, OFF_STAT, 32'h0);
      k++;
    end while (rdat[1:0] !== s && k < 40);
    chk(rdat[1:0] === s, "state wait");
  endtask
  task automatic go();
    change <= 1'b1;
    wcap(1'b1, 50);
    change <= 1'b0;
  endtask
  task automatic tpulse();
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [12:0] expo(input logic [3:0] s);
    logic [12:0] t [9] = '{13'h3c, 13'h7d, 13'hfa, 13'h1f4, 13'h3e8, 13'h7d0,
      13'hfa0, 13'h1770, 13'h1f40};
    return t[s];
  endfunction
  function automatic logic [31:0] rcam();
    asr_cam_s r;
    r = asr_cam_s'($urandom);
    r.illum_ctl = 2'(2 + $urandom % 2);
    r.intensity = 6'($urandom % 51);
    r.shutter = 4'($urandom % 9);
    r.gain = 4'(1 + $urandom % 15);
    r.black = 8'($urandom % 255) - 8'h7f;
    return 32'(r);
  endfunction
  // ==========================================
  // Main sequence
  initial begin
    {nrst, psel, penable, pwrite, change, present, trig, same, ill_q} = '0;
    {paddr, pwdata, ok_at, req_or} = '0;
    void'($urandom(32'h64789155));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    apb(1'b0, OFF_MODE, 32'h0); chk(rdat === 32'h0, "mode reset");
    apb(1'b0, OFF_SENSE, 32'h0); chk(rdat === 32'h1062, "sense reset");
    apb(1'b0, OFF_TMO, 32'h0); chk(rdat === 32'h1388, "timeout reset");
    apb(1'b0, OFF_CAM, 32'h0); chk(rdat === 32'h4d9f0, "camera reset");
    apb(1'b0, 8'h18, 32'h0); chk(rerr === 1'b1 && rdat === 32'h0, "unmapped");
    chk(SENS_O === 3'h2, "sensitivity reset");
    // Forwarding outside autosense
    tpulse();
    for (int i = 0; i < 5; i++) apb(1'b1, OFF_REQ, 32'h1 << i);
    // Let the monitor see the last request pulse
    @(posedge clk);
    chk(n_trig == 1 && req_or === 5'h1f, "forwarding in mode 0");
    apb(1'b1, OFF_MODE, 32'h3);
    tpulse();
    req_or = 5'h0;
    for (int i = 0; i < 6; i++) apb(1'b1, OFF_REQ, 32'h1 << i);
    chk(n_trig == 1 && req_or === 5'h0, "requests in autosense");
    apb(1'b0, OFF_STAT, 32'h0); chk(rdat[2] === 1'b1, "refusal flag");
    // Sensitivity 7 saturates to 4; guard on, window 1, ignore code 0
    apb(1'b1, OFF_SENSE, 32'h3818);
    apb(1'b0, OFF_SENSE, 32'h0); chk(rdat === 32'h2018, "sense readback");
    chk(SENS_O === SENS_MAX, "sensitivity clip");
    apb(1'b1, OFF_TMO, 32'h64);
    // Good read with random camera settings
    cam = rcam();
    c = asr_cam_s'(cam);
    apb(1'b1, OFF_CAM, cam);
    apb(1'b0, OFF_CAM, 32'h0); chk(rdat === cam, "camera readback");
    ok_at <= 4'h2;
    present <= 1'b1;
    go();
    apb(1'b1, OFF_CAM, rcam());
    chk(CAM_O === c, "settings latched");
    chk(WIN_W_O === 10'(752 - 188 * c.win_h), "width");
    chk(WIN_H_O === 9'(480 - 120 * c.win_v), "height");
    chk(EXPO_DIV_O === expo(c.shutter), "shutter");
    chk(ILLUM_O === (c.illum_ctl == ILL_PULSE && c.intensity != 6'h0), "light");
    wcap(1'b0, 200);
    repeat (2) @(posedge clk);
    chk(n_tx == 1 && GREEN_O === 1'b1 && GOOD_O === 1'b1 && RED_O === 1'b0, "good");
    apb(1'b0, OFF_STAT, 32'h0); chk(rdat[19:4] === 16'h1, "counter");
    present <= 1'b0;
    wst(2'h0);
    // Same symbol inside the guard window
    same <= 1'b1;
    present <= 1'b1;
    go();
    wcap(1'b0, 200);
    repeat (2) @(posedge clk);
    chk(n_tx == 1 && GOOD_O === 1'b0 && FAIL_O === 1'b0, "suppressed");
    apb(1'b0, OFF_STAT, 32'h0); chk(rdat[19:4] === 16'h1, "no count");
    present <= 1'b0;
    wst(2'h0);
    repeat (5100) @(posedge clk);
    present <= 1'b1;
    go();
    wcap(1'b0, 200);
    repeat (2) @(posedge clk);
    chk(n_tx == 2 && GOOD_O === 1'b1, "window over");
    present <= 1'b0;
    wst(2'h0);
    // Timeout with mirror order 2
    apb(1'b1, OFF_CAM, {2'h2, cam[29:6], ILL_OFF, cam[3:0]});
    ok_at <= 4'h0;
    present <= 1'b1;
    go();
    // Orientation output lags the latch by one cycle
    @(posedge clk);
    chk(MIRROR_O === 1'b0, "normal first");
    repeat (12) @(posedge clk);
    chk(MIRROR_O === 1'b1, "mirrored retry");
    chk(ILLUM_O === 1'b0, "light off in capture");
    wcap(1'b0, 1100);
    chk(n > 970 && n < 1010, "timeout length");
    repeat (2) @(posedge clk);
    chk(n_err == 1 && RED_O === 1'b1 && FAIL_O === 1'b1 && GOOD_O === 1'b0, "fail");
    // Object stays: ignore code 0 is 100 ms
    repeat (880) @(posedge clk);
    apb(1'b0, OFF_STAT, 32'h0); chk(rdat[1:0] === 2'h2, "still holding");
    repeat (150) @(posedge clk);
    apb(1'b0, OFF_STAT, 32'h0); chk(rdat[1:0] === 2'h0, "ignore time over");
    present <= 1'b0;
    // Flash on, then off
    apb(1'b1, OFF_SENSE, 32'h0418);
    n_ill = 0;
    repeat (3000) @(posedge clk);
    chk(n_ill > 0, "flash on");
    apb(1'b1, OFF_SENSE, 32'h0018);
    repeat (4) @(posedge clk);
    n_ill = 0;
    repeat (3000) @(posedge clk);
    chk(n_ill == 0 && ILLUM_O === 1'b0, "flash off");
    // Leaving autosense restores triggers
    apb(1'b1, OFF_MODE, 32'h1);
    tpulse();
    chk(n_trig == 2 && GREEN_O === 1'b0 && RED_O === 1'b0, "left autosense");
    test_done();
  end
endmodule // asr_top_tb_top
